// ==== common/ptio_params.svh ====
`ifndef PTIO_PARAMS_SVH
`define PTIO_PARAMS_SVH

// ==========================================================================
// Timing.
`define PTIO_CLK_HZ 25000000
`define PTIO_MS_CYCLES (`PTIO_CLK_HZ / 1000)
`define PTIO_FILT_US 600
`define PTIO_FILT_CYCLES ((`PTIO_FILT_US * (`PTIO_CLK_HZ / 1000000)))
`define PTIO_FLASH_HALF_MS 500
`define PTIO_PULSE_MS 100
`define PTIO_PV_MAX 20'hf423f

// ==========================================================================
// Register offsets.
`define PTIO_ADR_CTRL 8'h00
`define PTIO_ADR_SET1 8'h04
`define PTIO_ADR_SET2 8'h08
`define PTIO_ADR_PV 8'h0c
`define PTIO_ADR_STATUS 8'h10

// ==========================================================================
// Control register fields.
`define PTIO_CTRL_DOWN 0
`define PTIO_CTRL_OP_LO 1
`define PTIO_CTRL_OP_HI 2
`define PTIO_CTRL_RANGE_LO 3
`define PTIO_CTRL_RANGE_HI 5
`define PTIO_CTRL_DUAL 6
`define PTIO_CTRL_ABS 7
`define PTIO_CTRL_PULSE 8
`define PTIO_CTRL_RSTKEY 9
`define PTIO_CTRL_W 10

// ==========================================================================
// Reset values.
`define PTIO_CTRL_RST 10'h000
`define PTIO_SET1_RST 20'h00064
`define PTIO_SET2_RST 20'h00032

`endif

// ==== common/ptio_pkg.sv ====
package ptio_pkg;

  // ========================================================================
  // Start input behaviour.
  typedef enum logic [1:0] {
    PTIO_OP_NORMAL = 2'b00,
    PTIO_OP_INH_A2 = 2'b01,
    PTIO_OP_INH_A3 = 2'b10,
    PTIO_OP_ACCUM = 2'b11
  } ptio_op_e;

  // ========================================================================
  // Time ranges, each one count of the present value.
  typedef enum logic [2:0] {
    PTIO_RNG_1MS = 3'b000,
    PTIO_RNG_10MS = 3'b001,
    PTIO_RNG_100MS = 3'b010,
    PTIO_RNG_1S = 3'b011,
    PTIO_RNG_01MIN = 3'b100,
    PTIO_RNG_1MIN = 3'b101,
    PTIO_RNG_01H = 3'b110,
    PTIO_RNG_1H = 3'b111
  } ptio_range_e;

  typedef logic [19:0] ptio_pv_t;

endpackage : ptio_pkg

// ==== verilog/ptio_input_filter.sv ====
`timescale 1ns/10ps
`include "ptio_params.svh"

module ptio_input_filter #(
  parameter int unsigned FILT_CYCLES = `PTIO_FILT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pinIn,
  output logic levelOut
);

  logic sync1_q;
  logic sync2_q;
  logic level_q;
  logic [15:0] cnt_q;

  // ========================================================================
  // Two-stage synchroniser; only the second stage is looked at.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pinIn;
      sync2_q <= sync1_q;
    end
  end

  // A level must stay put for the whole window before it is accepted.
  // This costs latency but keeps contact bounce away from the count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      level_q <= 1'b0;
    end else if (sync2_q == level_q) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q == 16'(FILT_CYCLES - 1)) begin
      cnt_q <= 16'h0000;
      level_q <= sync2_q;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign levelOut = level_q;

endmodule : ptio_input_filter

// ==== verilog/ptio_timer.sv ====
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/10ps
`include "ptio_params.svh"

module ptio_timer #(
  parameter int unsigned MS_CYCLES = `PTIO_MS_CYCLES,
  parameter int unsigned FILT_CYCLES = `PTIO_FILT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic startIn,
  input wire logic resetIn,
  input wire logic gateIn,
  input wire logic resetKeyIn,
  input wire logic keyProtectIn,
  output logic firstOutput,
  output logic secondOutput,
  output logic keyProtectLed,
  output logic resetLed,
  output logic firstLed,
  output logic secondLed,
  output logic unitLed
);

  // ========================================================================
  // Input conditioning.
  logic [4:0] pinVec;
  logic [4:0] lvlVec;
  logic startLvl;
  logic resetLvl;
  logic gateLvl;
  logic resetKeyLvl;
  logic keyProtLvl;

  assign pinVec = {keyProtectIn, resetKeyIn, gateIn, resetIn, startIn};

  // Every pin sees the same filter, so all inputs share one latency.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : gFilt
      ptio_input_filter #(
        .FILT_CYCLES(FILT_CYCLES)
      ) uFilt (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(pinVec[gi]),
        .levelOut(lvlVec[gi])
      );
    end
  endgenerate

  assign startLvl = lvlVec[0];
  assign resetLvl = lvlVec[1];
  assign gateLvl = lvlVec[2];
  assign resetKeyLvl = lvlVec[3];
  assign keyProtLvl = lvlVec[4];

  // ========================================================================
  // Registers.
  logic [`PTIO_CTRL_W-1:0] ctrl_q;
  ptio_pkg::ptio_pv_t set1_q;
  ptio_pkg::ptio_pv_t set2_q;
  ptio_pkg::ptio_pv_t pv_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] selMask;
  logic wrEn;
  logic wrCfgOk;

  logic countDown;
  ptio_pkg::ptio_op_e opMode;
  ptio_pkg::ptio_range_e rangeSel;
  logic dualEn;
  logic absCfg;
  logic pulseMode;

  assign countDown = ctrl_q[`PTIO_CTRL_DOWN];
  assign opMode = ptio_pkg::ptio_op_e'(
    ctrl_q[`PTIO_CTRL_OP_HI:`PTIO_CTRL_OP_LO]);
  assign rangeSel = ptio_pkg::ptio_range_e'(
    ctrl_q[`PTIO_CTRL_RANGE_HI:`PTIO_CTRL_RANGE_LO]);
  assign dualEn = ctrl_q[`PTIO_CTRL_DUAL];
  assign absCfg = ctrl_q[`PTIO_CTRL_ABS];
  assign pulseMode = ctrl_q[`PTIO_CTRL_PULSE];

  // Byte lanes expand to a bit mask for partial writes.
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : gSel
      assign selMask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
    end
  endgenerate

  // A write lands on the edge where the master samples ack high.
  // The key protect switch locks the settings against bus writes.
  assign wrEn = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  assign wrCfgOk = wrEn & ~keyProtLvl;

  // Settings storage.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `PTIO_CTRL_RST;
      set1_q <= `PTIO_SET1_RST;
      set2_q <= `PTIO_SET2_RST;
    end else if (wrCfgOk) begin
      if (wb_adr_i == `PTIO_ADR_CTRL) begin
        ctrl_q <= (ctrl_q & ~selMask[`PTIO_CTRL_W-1:0]) |
                  (wb_dat_i[`PTIO_CTRL_W-1:0] &
                   selMask[`PTIO_CTRL_W-1:0]);
      end else if (wb_adr_i == `PTIO_ADR_SET1) begin
        set1_q <= (set1_q & ~selMask[19:0]) |
                  (wb_dat_i[19:0] & selMask[19:0]);
      end else if (wb_adr_i == `PTIO_ADR_SET2) begin
        set2_q <= (set2_q & ~selMask[19:0]) |
                  (wb_dat_i[19:0] & selMask[19:0]);
      end
    end
  end

  // ========================================================================
  // Timing control.
  logic resetAll;
  logic startPrev_q;
  logic runLatch_q;
  logic runEnable;
  logic doneAll;
  logic timeEn;
  ptio_pkg::ptio_pv_t elapsed;
  logic reach1;
  logic reach2;

  // The front key and the software key act like the reset pin.
  assign resetAll = resetLvl | resetKeyLvl | ctrl_q[`PTIO_CTRL_RSTKEY];

  // Measuring everything as elapsed time lets one compare serve both ways.
  assign elapsed = countDown ? (set1_q - pv_q) : pv_q;
  assign reach1 = (elapsed >= set1_q);
  assign reach2 = (elapsed >= set2_q);
  assign doneAll = reach1 & (~(dualEn & absCfg) | reach2);

  // Start input meaning depends on the operating mode.
  always_comb begin
    case (opMode)
      ptio_pkg::PTIO_OP_NORMAL: runEnable = runLatch_q;
      ptio_pkg::PTIO_OP_INH_A2: runEnable = ~startLvl;
      ptio_pkg::PTIO_OP_INH_A3: runEnable = ~startLvl;
      ptio_pkg::PTIO_OP_ACCUM: runEnable = startLvl;
      default: runEnable = 1'b0;
    endcase
  end

  // Reset outranks gate and start; gate only freezes.
  assign timeEn = runEnable & ~gateLvl & ~resetAll & ~doneAll;

  // Start edge latch for the normal mode; reset clears it first.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startPrev_q <= 1'b0;
      runLatch_q <= 1'b0;
    end else begin
      startPrev_q <= startLvl;
      if (resetAll) begin
        runLatch_q <= 1'b0;
      end else if (startLvl & ~startPrev_q) begin
        runLatch_q <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Time base.
  logic [15:0] msCnt_q;
  logic msTick;
  logic [21:0] rangeCnt_q;
  logic [21:0] rangeMs;
  logic pvStep;

  assign msTick = (msCnt_q == 16'(MS_CYCLES - 1));

  // Free running millisecond prescaler.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msCnt_q <= 16'h0000;
    end else if (msTick) begin
      msCnt_q <= 16'h0000;
    end else begin
      msCnt_q <= msCnt_q + 16'h0001;
    end
  end

  // Milliseconds per present value count for each range.
  always_comb begin
    case (rangeSel)
      ptio_pkg::PTIO_RNG_1MS: rangeMs = 22'h000001;
      ptio_pkg::PTIO_RNG_10MS: rangeMs = 22'h00000a;
      ptio_pkg::PTIO_RNG_100MS: rangeMs = 22'h000064;
      ptio_pkg::PTIO_RNG_1S: rangeMs = 22'h0003e8;
      ptio_pkg::PTIO_RNG_01MIN: rangeMs = 22'h001770;
      ptio_pkg::PTIO_RNG_1MIN: rangeMs = 22'h00ea60;
      ptio_pkg::PTIO_RNG_01H: rangeMs = 22'h057e40;
      ptio_pkg::PTIO_RNG_1H: rangeMs = 22'h36ee80;
      default: rangeMs = 22'h000001;
    endcase
  end

  assign pvStep = timeEn & msTick & (rangeCnt_q >= rangeMs - 22'h000001);

  // Fraction of the current count survives a gate, lost on reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rangeCnt_q <= 22'h000000;
    end else if (resetAll | pvStep) begin
      rangeCnt_q <= 22'h000000;
    end else if (timeEn & msTick) begin
      rangeCnt_q <= rangeCnt_q + 22'h000001;
    end
  end

  // Present value: elapsed when counting up, remaining when counting down.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pv_q <= 20'h00000;
    end else if (resetAll) begin
      pv_q <= countDown ? set1_q : 20'h00000;
    end else if (pvStep) begin
      if (countDown) begin
        pv_q <= (pv_q != 20'h00000) ? pv_q - 20'h00001 : pv_q;
      end else if (pv_q != `PTIO_PV_MAX) begin
        pv_q <= pv_q + 20'h00001;
      end
    end
  end

  // ========================================================================
  // Outputs.
  logic firstOut_q;
  logic secondOut_q;
  logic firstTarget;
  logic secondTarget;
  logic [15:0] pulseCnt_q;
  logic pulseDone_q;

  // Output pairing by configuration; single setup uses the second only.
  always_comb begin
    if (!dualEn) begin
      firstTarget = 1'b0;
      secondTarget = reach1;
    end else if (absCfg) begin
      firstTarget = reach1;
      secondTarget = reach2;
    end else begin
      firstTarget = reach2;
      secondTarget = reach1;
    end
  end

  // Pulse mode holds the second output for a fixed time, then drops it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulseCnt_q <= 16'h0000;
      pulseDone_q <= 1'b0;
    end else if (resetAll) begin
      pulseCnt_q <= 16'h0000;
      pulseDone_q <= 1'b0;
    end else if (secondOut_q & msTick & ~pulseDone_q) begin
      if (pulseCnt_q == 16'(`PTIO_PULSE_MS - 1)) begin
        pulseDone_q <= 1'b1;
      end else begin
        pulseCnt_q <= pulseCnt_q + 16'h0001;
      end
    end
  end

  // Outputs go off the cycle after the filtered reset is seen.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      firstOut_q <= 1'b0;
      secondOut_q <= 1'b0;
    end else if (resetAll) begin
      firstOut_q <= 1'b0;
      secondOut_q <= 1'b0;
    end else begin
      firstOut_q <= firstTarget;
      secondOut_q <= secondTarget & ~(pulseMode & pulseDone_q);
    end
  end

  // ========================================================================
  // Indicators.
  logic [15:0] flashCnt_q;
  logic flashPhase_q;
  logic coarseRange;
  logic keyProtLed_q;
  logic resetLed_q;
  logic firstLed_q;
  logic secondLed_q;
  logic unitLed_q;

  assign coarseRange = (rangeSel == ptio_pkg::PTIO_RNG_1MIN) |
                       (rangeSel == ptio_pkg::PTIO_RNG_01H) |
                       (rangeSel == ptio_pkg::PTIO_RNG_1H);

  // Half second blink phase.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flashCnt_q <= 16'h0000;
      flashPhase_q <= 1'b0;
    end else if (msTick) begin
      if (flashCnt_q == 16'(`PTIO_FLASH_HALF_MS - 1)) begin
        flashCnt_q <= 16'h0000;
        flashPhase_q <= ~flashPhase_q;
      end else begin
        flashCnt_q <= flashCnt_q + 16'h0001;
      end
    end
  end

  // Coarse ranges change too slowly to show life, hence the blinking unit.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keyProtLed_q <= 1'b0;
      resetLed_q <= 1'b0;
      firstLed_q <= 1'b0;
      secondLed_q <= 1'b0;
      unitLed_q <= 1'b0;
    end else begin
      keyProtLed_q <= keyProtLvl;
      resetLed_q <= resetAll;
      firstLed_q <= firstTarget & ~resetAll;
      secondLed_q <= secondTarget & ~resetAll &
                     ~(pulseMode & pulseDone_q);
      unitLed_q <= (coarseRange & timeEn) ? flashPhase_q
                                          : 1'b1;
    end
  end

  // ========================================================================
  // Bus answer: ack one cycle after the request, data sampled with it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
      if (wb_adr_i == `PTIO_ADR_CTRL) begin
        rdat_q <= {22'h000000, ctrl_q};
      end else if (wb_adr_i == `PTIO_ADR_SET1) begin
        rdat_q <= {12'h000, set1_q};
      end else if (wb_adr_i == `PTIO_ADR_SET2) begin
        rdat_q <= {12'h000, set2_q};
      end else if (wb_adr_i == `PTIO_ADR_PV) begin
        rdat_q <= {12'h000, pv_q};
      end else if (wb_adr_i == `PTIO_ADR_STATUS) begin
        rdat_q <= {23'h000000, gateLvl, startLvl, keyProtLvl, resetAll,
                   secondOut_q, firstOut_q, reach2, reach1, timeEn};
      end else begin
        rdat_q <= 32'h00000000;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign firstOutput = firstOut_q;
  assign secondOutput = secondOut_q;
  assign keyProtectLed = keyProtLed_q;
  assign resetLed = resetLed_q;
  assign firstLed = firstLed_q;
  assign secondLed = secondLed_q;
  assign unitLed = unitLed_q;

endmodule : ptio_timer

// ==== testbench/ptio_timer_monitor.sv ====
`timescale 1ns/10ps
// ==========================================
// Port checks on the preset timer.
module ptio_timer_monitor #(
  parameter int unsigned MS_CYCLES = 25000,
  parameter int unsigned FILT_CYCLES = 15000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic startIn,
  input wire logic resetIn,
  input wire logic gateIn,
  input wire logic resetKeyIn,
  input wire logic keyProtectIn,
  input wire logic firstOutput,
  input wire logic secondOutput,
  input wire logic keyProtectLed,
  input wire logic resetLed,
  input wire logic firstLed,
  input wire logic secondLed,
  input wire logic unitLed
);
  // Margin covers the sync flops, the filter and the output register.
  localparam int unsigned LAT = FILT_CYCLES + 5;
  int unsigned rstHi_q, keyHi_q, keyLo_q, gateHi_q;
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Level counters restart on reset, because the filters restart too.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstHi_q <= 0;
      keyHi_q <= 0;
      keyLo_q <= 0;
      gateHi_q <= 0;
    end else begin
      rstHi_q <= resetIn ? rstHi_q + 1 : 0;
      keyHi_q <= keyProtectIn ? keyHi_q + 1 : 0;
      keyLo_q <= keyProtectIn ? 0 : keyLo_q + 1;
      gateHi_q <= gateIn ? gateHi_q + 1 : 0;
    end
  end
  property p_ackPulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ackPulse: assert property (p_ackPulse)
    else $error("ack held longer than one cycle");
  property p_ackAnswer;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ackAnswer: assert property (p_ackAnswer)
    else $error("request not answered next cycle");
  property p_unmapped;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == 8'h14
      |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_rstOff;
    rstHi_q >= LAT |-> !firstOutput && !secondOutput;
  endproperty
  a_rstOff: assert property (p_rstOff)
    else $error("output on while reset held");
  property p_rstLed;
    rstHi_q >= LAT |-> resetLed;
  endproperty
  a_rstLed: assert property (p_rstLed)
    else $error("reset indicator dark during reset");
  property p_keyOn;
    keyHi_q >= LAT |-> keyProtectLed;
  endproperty
  a_keyOn: assert property (p_keyOn)
    else $error("key protect indicator dark");
  property p_keyOff;
    keyLo_q >= LAT |-> !keyProtectLed;
  endproperty
  a_keyOff: assert property (p_keyOff)
    else $error("key protect indicator lit");
  property p_firstLed;
    $rose(firstOutput) |-> ##[0:2] firstLed;
  endproperty
  a_firstLed: assert property (p_firstLed)
    else $error("first indicator does not follow output");
  property p_secondLed;
    $fell(secondOutput) |-> ##[0:2] !secondLed;
  endproperty
  a_secondLed: assert property (p_secondLed)
    else $error("second indicator does not follow output");
  property p_gateHold;
    gateHi_q >= LAT && rstHi_q == 0 |=> !$rose(secondOutput);
  endproperty
  a_gateHold: assert property (p_gateHold)
    else $error("output rose while gate held");
endmodule : ptio_timer_monitor

// ==== testbench/ptio_pin_source.sv ====
`timescale 1ns/10ps
// ==========================================
// Switch and sensor model on the timer's input pins.
module ptio_pin_source #(
  parameter int unsigned RST_MIN = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic startReq,
  input wire logic resetReq,
  input wire logic gateReq,
  input wire logic keyReq,
  input wire logic protReq,
  output logic startIn,
  output logic resetIn,
  output logic gateIn,
  output logic resetKeyIn,
  output logic keyProtectIn
);
  int unsigned hold_q;
  // A short reset request is stretched to the minimum width.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= 0;
    end else begin
      hold_q <= resetReq ? RST_MIN - 1 : (hold_q != 0 ? hold_q - 1 : 0);
    end
  end
  // Requests come just after an edge, so pins follow them directly.
  assign resetIn = resetReq || hold_q != 0;
  assign startIn = startReq;
  assign gateIn = gateReq;
  assign resetKeyIn = keyReq;
  assign keyProtectIn = protReq;
endmodule : ptio_pin_source

// ==== testbench/ptio_timer_test.sv ====
`timescale 1ns/10ps
`include "ptio_params.svh"
// ==========================================
// Bench for the preset timer.
module ptio_timer_test;
  localparam int unsigned MS = 10;
  localparam int unsigned FILT = 4;
  localparam int unsigned SETTLE = FILT + 6;
  logic clk, rst_n, wbCyc, wbStb, wbWe, wbAck;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR, rdA;
  logic startReq, resetReq, gateReq, keyReq, protReq;
  logic startIn, resetIn, gateIn, resetKeyIn, keyProtectIn;
  logic firstOutput, secondOutput, keyProtectLed, resetLed;
  logic firstLed, secondLed, unitLed;
  logic [1:0] seen;
  logic [7:0] rAdr [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14};
  logic [31:0] rVal [5] = '{32'h0, 32'h64, 32'h32, 32'h0, 32'h0};
  int unsigned fails = 0;
  int unsigned total_checks = 0;
  int unsigned cycles = 0;
  ptio_pin_source #(.RST_MIN(MS)) u_ptio_pin_source (
    .clk(clk), .rst_n(rst_n), .startReq(startReq), .resetReq(resetReq),
    .gateReq(gateReq), .keyReq(keyReq), .protReq(protReq),
    .startIn(startIn), .resetIn(resetIn), .gateIn(gateIn),
    .resetKeyIn(resetKeyIn), .keyProtectIn(keyProtectIn));
  ptio_timer #(.MS_CYCLES(MS), .FILT_CYCLES(FILT)) u_ptio_timer (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
    .startIn(startIn), .resetIn(resetIn), .gateIn(gateIn),
    .resetKeyIn(resetKeyIn), .keyProtectIn(keyProtectIn),
    .firstOutput(firstOutput), .secondOutput(secondOutput),
    .keyProtectLed(keyProtectLed), .resetLed(resetLed),
    .firstLed(firstLed), .secondLed(secondLed), .unitLed(unitLed));
  // Free-running 25 MHz clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  // A hang is cut short well beyond the longest expected run.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // One classic cycle; the request stands until ack is sampled high.
  task automatic wbCycle(input logic w, input logic [7:0] a,
                         input logic [31:0] d, output logic [31:0] r);
    int guard;
    guard = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatW <= d;
    do begin
      @(posedge clk);
      guard++;
    end while (wbAck !== 1'b1 && guard < 100);
    if (guard >= 100) fails++;
    r = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wbCycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wbCycle(1'b1, a, d, r);
  endtask : wr
  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : checkVal
  task automatic checkBit(input logic got, input logic exp);
    checkVal({31'h0, got}, {31'h0, exp});
  endtask : checkBit
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wbCycle(1'b0, a, 32'h0, r);
    checkVal(r, exp);
  endtask : rdChk
  // Load settings, then a reset pin pulse reloads the present value.
  task automatic arm(input logic [31:0] c, input logic [31:0] s1,
                     input logic [31:0] s2);
    wr(`PTIO_ADR_SET1, s1);
    wr(`PTIO_ADR_SET2, s2);
    wr(`PTIO_ADR_CTRL, c);
    resetReq <= 1'b1;
    tick(1);
    resetReq <= 1'b0;
    tick(MS + SETTLE);
  endtask : arm
  task automatic startPulse;
    startReq <= 1'b1;
    tick(SETTLE);
    startReq <= 1'b0;
  endtask : startPulse
  // Main sequence; every count lasts MS clock cycles in the 1 ms range.
  initial begin
    {rst_n, wbCyc, wbStb, wbWe, wbAdr, wbDatW} <= '0;
    {startReq, resetReq, gateReq, keyReq, protReq} <= '0;
    wbSel <= 4'hf;
    tick(4);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) rdChk(rAdr[i], rVal[i]);
    checkBit(unitLed, 1'b1);
    wr(`PTIO_ADR_PV, 32'h55);
    rdChk(`PTIO_ADR_PV, 32'h0);
    $display("test reset values done");
    arm(32'h0, 32'h5, 32'h3);
    startPulse();
    tick(20);
    checkBit(secondOutput, 1'b0);
    tick(60);
    checkBit(secondOutput, 1'b1);
    checkBit(firstOutput, 1'b0);
    checkBit(secondLed, 1'b1);
    rdChk(`PTIO_ADR_PV, 32'h5);
    // Done, both reached, second output on; nothing else active.
    rdChk(`PTIO_ADR_STATUS, 32'h16);
    resetReq <= 1'b1;
    tick(SETTLE + 2);
    checkBit(secondOutput, 1'b0);
    checkBit(resetLed, 1'b1);
    rdChk(`PTIO_ADR_PV, 32'h0);
    resetReq <= 1'b0;
    tick(MS + SETTLE);
    checkBit(resetLed, 1'b0);
    $display("test up count done");
    arm(32'h1, 32'h5, 32'h3);
    rdChk(`PTIO_ADR_PV, 32'h5);
    startPulse();
    tick(70);
    rdChk(`PTIO_ADR_PV, 32'h0);
    checkBit(secondOutput, 1'b1);
    arm(32'h100, 32'h5, 32'h3);
    startPulse();
    tick(70);
    checkBit(secondOutput, 1'b1);
    tick(100 * MS + 10);
    checkBit(secondOutput, 1'b0);
    $display("test down and pulse done");
    arm(32'h0, 32'h5, 32'h3);
    startPulse();
    gateReq <= 1'b1;
    tick(SETTLE);
    wbCycle(1'b0, `PTIO_ADR_PV, 32'h0, rdA);
    tick(60);
    rdChk(`PTIO_ADR_PV, rdA);
    checkBit(secondOutput, 1'b0);
    resetReq <= 1'b1;
    tick(SETTLE);
    rdChk(`PTIO_ADR_PV, 32'h0);
    resetReq <= 1'b0;
    gateReq <= 1'b0;
    tick(MS + SETTLE);
    $display("test gate done");
    arm(32'h6, 32'h5, 32'h3);
    tick(40);
    rdChk(`PTIO_ADR_PV, 32'h0);
    startReq <= 1'b1;
    tick(30);
    startReq <= 1'b0;
    tick(SETTLE);
    wbCycle(1'b0, `PTIO_ADR_PV, 32'h0, rdA);
    tick(40);
    rdChk(`PTIO_ADR_PV, rdA);
    startReq <= 1'b1;
    tick(60);
    checkBit(secondOutput, 1'b1);
    // Start is raised at the top, so no edge assigns it twice.
    for (int m = 1; m < 3; m++) begin
      startReq <= 1'b1;
      arm(32'(m << 1), 32'h5, 32'h3);
      tick(60);
      rdChk(`PTIO_ADR_PV, 32'h0);
      startReq <= 1'b0;
      tick(70);
      checkBit(secondOutput, 1'b1);
    end
    $display("test start modes done");
    for (int ab = 0; ab < 2; ab++) begin
      arm(32'h40 | 32'(ab << 7), ab ? 32'h3 : 32'h8, ab ? 32'h8 : 32'h3);
      startPulse();
      tick(50);
      checkBit(firstOutput, 1'b1);
      checkBit(secondOutput, 1'b0);
      checkBit(firstLed, 1'b1);
      tick(60);
      checkBit(secondOutput, 1'b1);
    end
    $display("test dual outputs done");
    protReq <= 1'b1;
    tick(SETTLE);
    checkBit(keyProtectLed, 1'b1);
    wr(`PTIO_ADR_SET1, 32'h7);
    rdChk(`PTIO_ADR_SET1, 32'h3);
    protReq <= 1'b0;
    tick(SETTLE);
    checkBit(keyProtectLed, 1'b0);
    keyReq <= 1'b1;
    tick(SETTLE);
    checkBit(resetLed, 1'b1);
    keyReq <= 1'b0;
    tick(SETTLE);
    wr(`PTIO_ADR_CTRL, 32'h200);
    tick(3);
    checkBit(resetLed, 1'b1);
    $display("test keys done");
    arm(32'h0, 32'h5, 32'h3);
    startReq <= 1'b1;
    tick(2);
    startReq <= 1'b0;
    tick(80);
    rdChk(`PTIO_ADR_PV, 32'h0);
    // The 10 ms range needs ten millisecond ticks per count.
    arm(32'h8, 32'h5, 32'h3);
    startPulse();
    tick(70);
    rdChk(`PTIO_ADR_PV, 32'h0);
    tick(100);
    rdChk(`PTIO_ADR_PV, 32'h1);
    arm(32'h38, 32'h5, 32'h3);
    startPulse();
    seen = 2'b00;
    repeat (12000) begin
      @(posedge clk);
      seen[unitLed] = 1'b1;
    end
    checkBit(seen[0], 1'b1);
    checkBit(seen[1], 1'b1);
    $display("test glitch and flash done");
    print_verdict();
  end
endmodule : ptio_timer_test
bind ptio_timer ptio_timer_monitor #(.MS_CYCLES(MS_CYCLES),
  .FILT_CYCLES(FILT_CYCLES)) u_ptio_timer_monitor (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .startIn(startIn), .resetIn(resetIn), .gateIn(gateIn),
  .resetKeyIn(resetKeyIn), .keyProtectIn(keyProtectIn),
  .firstOutput(firstOutput), .secondOutput(secondOutput),
  .keyProtectLed(keyProtectLed), .resetLed(resetLed),
  .firstLed(firstLed), .secondLed(secondLed), .unitLed(unitLed));
